// File: design/scpm_top.sv
// System clock selection, oscillator control and halt mode controller
//
// Contract
// RULE1: Selector codes 000-110 give fast clock divided 1..64, code 111 slow clock.
// RULE2: Fast keep-on-halt bit decides whether fast oscillator runs while halted.
// RULE3: Slow keep-on-halt bit decides whether slow oscillator runs while halted.
// RULE4: Switch completes after four current ticks plus one target-source edge.
// RULE5: Software waits the switch delay before timing-critical work on new source.
// RULE6: Enabling fast oscillator clears stable flag until oscillator settles.
// RULE7: Fast enable turns oscillator on or off; resets to 1, flag resets 0.
// RULE8: Unused bits of both clock registers read as zero.
// RULE9: Halt with both keep bits 0 enters sleep; only watchdog clock remains.
// RULE10: Halt with fast 0, slow 1 stops fast clock, keeps slow clock.
// RULE11: Halt with both keep bits 1 keeps both clocks running.
// RULE12: Halt entry sets power-down flag and clears watchdog time-out flag.
// RULE13: Halt entry clears watchdog counter; enable decides whether it resumes.
// RULE14: While halted, state is held and execution stays stopped.
// RULE15: Switch to slow clock completes only once slow oscillator is stable.
// RULE16: Software polls stable flag before returning to fast clock.
// RULE17: Halt with fast 1, slow 0 keeps fast clock, stops slow clock.
// RULE18: Fast clock is the 8 MHz oscillator, slow clock the low-frequency one.
// RULE19: Separate gated fast and slow clock enables follow run state and keep bits.
`timescale 1ns/1ps
module scpm_top #(
  parameter logic [15:0] FAST_STAB_TICKS = 16'h0400,
  parameter logic [15:0] SLOW_STAB_TICKS = 16'h0010
) (
  input  wire logic                  CLK,
  input  wire logic                  NRST,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic                  HALT_REQ,
  input  wire logic                  WAKE,
  input  wire logic                  WDT_EN,
  input  wire logic                  WDT_TIMEOUT,
  input  wire logic                  CLR_WDT_CMD,
  output scpm_pkg::scpm_clk_en_t     CLK_EN,
  output logic                       CPU_HALTED,
  output logic                       WDT_CLR,
  output logic                       PWR_DOWN_FLAG,
  output logic                       WDT_TO_FLAG,
  output logic                       IRQ
);

  // Register state
  logic [2:0]                   code_sel_q, code_sel_d;
  logic [2:0]                   cur_code_q, cur_code_d;
  logic                         keep_fast_q, keep_fast_d;
  logic                         keep_slow_q, keep_slow_d;
  logic                         fosc_en_q, fosc_en_d;
  logic                         pdf_q, pdf_d;
  logic                         to_q, to_d;
  logic [scpm_pkg::IRQ_W-1:0]   sts_q, sts_d;
  logic [scpm_pkg::IRQ_W-1:0]   msk_q, msk_d;
  scpm_pkg::scpm_state_t        state_q, state_d;
  logic                         busy_q, busy_d;
  logic [2:0]                   sw_cnt_q, sw_cnt_d;
  logic [scpm_pkg::ACC_W-1:0]   facc_q, facc_d;
  logic [scpm_pkg::ACC_W-1:0]   sacc_q, sacc_d;
  logic [15:0]                  fstab_q, fstab_d;
  logic [15:0]                  sstab_q, sstab_d;
  logic [5:0]                   pre_q, pre_d;
  logic                         fstable_prev_q;
  logic                         pready_q, pready_d;
  logic                         pslverr_q, pslverr_d;
  logic [31:0]                  prdata_q, prdata_d;
  logic                         wdt_clr_q;
  scpm_pkg::scpm_clk_en_t       clk_en_q, clk_en_d;

  // Combinational helpers
  logic                         halted, fosc_on, sosc_on;
  logic                         fast_raw, slow_raw, fast_stable, slow_stable;
  logic                         fast_tick, slow_tick, cur_tick, tgt_tick;
  logic                         cur_live, tgt_ready, halt_entry, wake_evt, switch_done;
  logic                         acc, wr, wr_sel, wr_fosc, wr_sts, wr_msk, mapped;
  logic [31:0]                  rd_word;
  logic [scpm_pkg::IRQ_W-1:0]   ev;

  localparam logic [scpm_pkg::ACC_W-1:0] CLK_K  = scpm_pkg::ACC_W'(scpm_pkg::CLK_KHZ);
  localparam logic [scpm_pkg::ACC_W-1:0] FAST_K = scpm_pkg::ACC_W'(scpm_pkg::FAST_KHZ);
  localparam logic [scpm_pkg::ACC_W-1:0] SLOW_K = scpm_pkg::ACC_W'(scpm_pkg::SLOW_KHZ);

  // Divided clock tick for a selector code
  function automatic logic div_tick(input logic [2:0] code, input logic ft,
                                    input logic st, input logic [5:0] pre);
    logic [5:0] mask;
    mask = 6'((7'h01 << code) - 7'h01);
    if (code == scpm_pkg::CODE_SLOW) begin
      div_tick = st; // RULE1
    end else begin
      div_tick = ft & ((pre & mask) == 6'h00); // RULE1
    end
  endfunction : div_tick

  // Oscillator run conditions
  assign halted  = (state_q != scpm_pkg::ST_RUN);
  assign fosc_on = fosc_en_q & (~halted | keep_fast_q); // RULE2 RULE7
  assign sosc_on = ~halted | keep_slow_q | WDT_EN;      // RULE3 RULE9

  // Oscillator models and stabilisation counters
  always_comb begin
    facc_d   = facc_q;
    sacc_d   = sacc_q;
    fast_raw = 1'b0;
    slow_raw = 1'b0;
    fstab_d  = fstab_q;
    sstab_d  = sstab_q;
    if (!fosc_on) begin
      facc_d  = '0;
      fstab_d = 16'h0000; // RULE6
    end else if (facc_q + FAST_K >= CLK_K) begin
      facc_d   = facc_q + FAST_K - CLK_K; // RULE18
      fast_raw = 1'b1;
    end else begin
      facc_d = facc_q + FAST_K;
    end
    if (!sosc_on) begin
      sacc_d  = '0;
      sstab_d = 16'h0000;
    end else if (sacc_q + SLOW_K >= CLK_K) begin
      sacc_d   = sacc_q + SLOW_K - CLK_K; // RULE18
      slow_raw = 1'b1;
    end else begin
      sacc_d = sacc_q + SLOW_K;
    end
    if (fast_raw && fstab_q != FAST_STAB_TICKS) begin
      fstab_d = fstab_q + 16'h0001; // RULE6
    end
    if (slow_raw && sstab_q != SLOW_STAB_TICKS) begin
      sstab_d = sstab_q + 16'h0001;
    end
  end

  assign fast_stable = (fstab_q == FAST_STAB_TICKS);
  assign slow_stable = (sstab_q == SLOW_STAB_TICKS);
  assign fast_tick   = fast_raw & fast_stable;
  assign slow_tick   = slow_raw & slow_stable;
  assign pre_d       = fast_tick ? pre_q + 6'h01 : pre_q;

  // Source ticks for current and target selector codes
  assign cur_tick  = div_tick(cur_code_q, fast_tick, slow_tick, pre_q);
  assign tgt_tick  = div_tick(code_sel_q, fast_tick, slow_tick, pre_q);
  assign cur_live  = (cur_code_q == scpm_pkg::CODE_SLOW) ? slow_stable : fast_stable;
  assign tgt_ready = (code_sel_q == scpm_pkg::CODE_SLOW) ? slow_stable : fast_stable;

  // APB decode; access takes two cycles, the second carries PREADY
  assign acc     = PSEL & PENABLE;
  assign wr      = acc & pready_q & PWRITE;
  assign wr_sel  = wr & (PADDR == scpm_pkg::OFF_CLK_SEL);
  assign wr_fosc = wr & (PADDR == scpm_pkg::OFF_FOSC_CTL);
  assign wr_sts  = wr & (PADDR == scpm_pkg::OFF_IRQ_STS);
  assign wr_msk  = wr & (PADDR == scpm_pkg::OFF_IRQ_MSK);
  assign mapped  = (PADDR == scpm_pkg::OFF_CLK_SEL) | (PADDR == scpm_pkg::OFF_FOSC_CTL) |
                   (PADDR == scpm_pkg::OFF_PWR_STS) | (PADDR == scpm_pkg::OFF_IRQ_STS) |
                   (PADDR == scpm_pkg::OFF_IRQ_MSK);

  // Read mux; unused bits stay zero
  always_comb begin
    rd_word = 32'h0000_0000; // RULE8
    case (PADDR)
      scpm_pkg::OFF_CLK_SEL: begin
        rd_word[scpm_pkg::SEL_CODE_MSB:scpm_pkg::SEL_CODE_LSB] = code_sel_q;
        rd_word[scpm_pkg::SEL_KEEP_FAST] = keep_fast_q;
        rd_word[scpm_pkg::SEL_KEEP_SLOW] = keep_slow_q;
      end
      scpm_pkg::OFF_FOSC_CTL: begin
        rd_word[scpm_pkg::FOSC_STABLE] = fast_stable; // RULE7
        rd_word[scpm_pkg::FOSC_ENABLE] = fosc_en_q;
      end
      scpm_pkg::OFF_PWR_STS: begin
        rd_word[scpm_pkg::PST_PDF]     = pdf_q;
        rd_word[scpm_pkg::PST_TO]      = to_q;
        rd_word[scpm_pkg::PST_BUSY]    = busy_q;
        rd_word[scpm_pkg::PST_SLOW_OK] = slow_stable;
        rd_word[scpm_pkg::PST_CUR_MSB:scpm_pkg::PST_CUR_LSB] = cur_code_q;
      end
      scpm_pkg::OFF_IRQ_STS: rd_word[scpm_pkg::IRQ_W-1:0] = sts_q;
      scpm_pkg::OFF_IRQ_MSK: rd_word[scpm_pkg::IRQ_W-1:0] = msk_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus handshake and configuration writes
  always_comb begin
    pready_d    = acc & ~pready_q;
    pslverr_d   = acc & ~pready_q & ~mapped;
    prdata_d    = (acc & ~pready_q) ? rd_word : prdata_q;
    code_sel_d  = code_sel_q;
    keep_fast_d = keep_fast_q;
    keep_slow_d = keep_slow_q;
    fosc_en_d   = fosc_en_q;
    msk_d       = msk_q;
    if (wr_sel) begin
      code_sel_d  = PWDATA[scpm_pkg::SEL_CODE_MSB:scpm_pkg::SEL_CODE_LSB];
      keep_fast_d = PWDATA[scpm_pkg::SEL_KEEP_FAST]; // RULE2
      keep_slow_d = PWDATA[scpm_pkg::SEL_KEEP_SLOW]; // RULE3
    end
    if (wr_fosc) begin
      fosc_en_d = PWDATA[scpm_pkg::FOSC_ENABLE]; // RULE7
    end
    if (wr_msk) begin
      msk_d = PWDATA[scpm_pkg::IRQ_W-1:0];
    end
  end

  // Clock switch sequencer
  always_comb begin
    busy_d      = busy_q;
    sw_cnt_d    = sw_cnt_q;
    cur_code_d  = cur_code_q;
    switch_done = 1'b0;
    if (wr_sel) begin
      busy_d   = (PWDATA[scpm_pkg::SEL_CODE_MSB:scpm_pkg::SEL_CODE_LSB] != cur_code_q);
      sw_cnt_d = 3'h0;
    end else if (busy_q) begin
      if (sw_cnt_q != scpm_pkg::SWITCH_CUR_TICKS && cur_live) begin
        sw_cnt_d = cur_tick ? sw_cnt_q + 3'h1 : sw_cnt_q; // RULE4
      end else if (tgt_tick && tgt_ready) begin
        cur_code_d  = code_sel_q; // RULE4 RULE15
        busy_d      = 1'b0;
        switch_done = 1'b1;
      end
    end
  end

  // Halt and wake state machine
  always_comb begin
    state_d    = state_q;
    halt_entry = 1'b0;
    wake_evt   = 1'b0;
    case (state_q)
      scpm_pkg::ST_RUN: begin
        if (HALT_REQ) begin
          halt_entry = 1'b1; // RULE12 RULE13
          case ({keep_fast_q, keep_slow_q})
            2'b00:   state_d = scpm_pkg::ST_SLEEP;     // RULE9
            2'b01:   state_d = scpm_pkg::ST_SLOW_ONLY; // RULE10
            2'b11:   state_d = scpm_pkg::ST_BOTH;      // RULE11
            default: state_d = scpm_pkg::ST_FAST_ONLY; // RULE17
          endcase
        end
      end
      scpm_pkg::ST_SLEEP, scpm_pkg::ST_SLOW_ONLY,
      scpm_pkg::ST_BOTH, scpm_pkg::ST_FAST_ONLY: begin
        if (WAKE) begin
          state_d  = scpm_pkg::ST_RUN; // RULE14
          wake_evt = 1'b1;
        end
      end
      default: state_d = scpm_pkg::ST_RUN;
    endcase
  end

  // Power-down and time-out flags, interrupt status; set wins over clear
  always_comb begin
    pdf_d = halt_entry | (pdf_q & ~CLR_WDT_CMD); // RULE12
    to_d  = WDT_TIMEOUT | (to_q & ~halt_entry);  // RULE12
    ev    = '0;
    ev[scpm_pkg::EV_SWITCH_DONE] = switch_done;
    ev[scpm_pkg::EV_FAST_STABLE] = fast_stable & ~fstable_prev_q;
    ev[scpm_pkg::EV_WAKE]        = wake_evt;
    sts_d = ev | (sts_q & ~(wr_sts ? PWDATA[scpm_pkg::IRQ_W-1:0] : '0));
  end

  // Gated clock enables; system clock stops while halted
  always_comb begin
    clk_en_d.sys  = ~halted & cur_tick;                  // RULE9 RULE14
    clk_en_d.fast = fast_tick & (~halted | keep_fast_q); // RULE19
    clk_en_d.slow = slow_tick & (~halted | keep_slow_q); // RULE19
    clk_en_d.internal_slow_oscillator = slow_tick;                           // RULE9
  end

  // State registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      code_sel_q     <= scpm_pkg::RST_CODE;
      cur_code_q     <= scpm_pkg::RST_CODE;
      keep_fast_q    <= scpm_pkg::RST_KEEP;
      keep_slow_q    <= scpm_pkg::RST_KEEP;
      fosc_en_q      <= scpm_pkg::RST_FOSC_EN; // RULE7
      pdf_q          <= 1'b0;
      to_q           <= 1'b0;
      sts_q          <= '0;
      msk_q          <= '0;
      state_q        <= scpm_pkg::ST_RUN;
      busy_q         <= 1'b0;
      sw_cnt_q       <= 3'h0;
      facc_q         <= '0;
      sacc_q         <= '0;
      fstab_q        <= 16'h0000;
      sstab_q        <= 16'h0000;
      pre_q          <= 6'h00;
      fstable_prev_q <= 1'b0;
      pready_q       <= 1'b0;
      pslverr_q      <= 1'b0;
      prdata_q       <= 32'h0000_0000;
      wdt_clr_q      <= 1'b0;
      clk_en_q       <= '0;
    end else begin
      code_sel_q     <= code_sel_d;
      cur_code_q     <= cur_code_d;
      keep_fast_q    <= keep_fast_d;
      keep_slow_q    <= keep_slow_d;
      fosc_en_q      <= fosc_en_d;
      pdf_q          <= pdf_d;
      to_q           <= to_d;
      sts_q          <= sts_d;
      msk_q          <= msk_d;
      state_q        <= state_d;
      busy_q         <= busy_d;
      sw_cnt_q       <= sw_cnt_d;
      facc_q         <= facc_d;
      sacc_q         <= sacc_d;
      fstab_q        <= fstab_d;
      sstab_q        <= sstab_d;
      pre_q          <= pre_d;
      fstable_prev_q <= fast_stable;
      pready_q       <= pready_d;
      pslverr_q      <= pslverr_d;
      prdata_q       <= prdata_d;
      wdt_clr_q      <= halt_entry; // RULE13
      clk_en_q       <= clk_en_d;
    end
  end

  // Outputs
  assign PRDATA        = prdata_q;
  assign PREADY        = pready_q;
  assign PSLVERR       = pslverr_q;
  assign CLK_EN        = clk_en_q;
  assign CPU_HALTED    = halted; // RULE14
  assign WDT_CLR       = wdt_clr_q;
  assign PWR_DOWN_FLAG = pdf_q;
  assign WDT_TO_FLAG   = to_q;
  assign IRQ           = |(sts_q & msk_q);

endmodule : scpm_top

// File: design/scpm_pkg.sv
// Shared constants and types for the system clock and power mode controller
package scpm_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFF_CLK_SEL   = 8'h00;
  localparam logic [7:0] OFF_FOSC_CTL  = 8'h04;
  localparam logic [7:0] OFF_PWR_STS   = 8'h08;
  localparam logic [7:0] OFF_IRQ_STS   = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MSK   = 8'h10;

  // Field positions of system_clock_select
  localparam int SEL_CODE_LSB  = 5;
  localparam int SEL_CODE_MSB  = 7;
  localparam int SEL_KEEP_FAST = 1;
  localparam int SEL_KEEP_SLOW = 0;

  // Field positions of fast_osc_control
  localparam int FOSC_STABLE = 1;
  localparam int FOSC_ENABLE = 0;

  // Field positions of the power status word
  localparam int PST_PDF      = 0;
  localparam int PST_TO       = 1;
  localparam int PST_BUSY     = 2;
  localparam int PST_SLOW_OK  = 3;
  localparam int PST_CUR_LSB  = 5;
  localparam int PST_CUR_MSB  = 7;

  // Interrupt event bits
  localparam int IRQ_W          = 3;
  localparam int EV_SWITCH_DONE = 0;
  localparam int EV_FAST_STABLE = 1;
  localparam int EV_WAKE        = 2;

  // Reset values and the slow-clock selector code
  localparam logic [2:0] RST_CODE      = 3'h0;
  localparam logic       RST_KEEP      = 1'b0;
  localparam logic       RST_FOSC_EN   = 1'b1;
  localparam logic [2:0] CODE_SLOW     = 3'h7;

  // Rates in kHz; oscillator ticks come from fractional accumulators on CLK
  localparam int CLK_KHZ  = 25000;
  localparam int FAST_KHZ = 8000;
  localparam int SLOW_KHZ = 32;
  localparam int ACC_W    = 15;

  // Clock switch wait: current system clock periods before the handover
  localparam logic [2:0] SWITCH_CUR_TICKS = 3'h4;

  // Operating states
  typedef enum logic [2:0] {
    ST_RUN, ST_SLEEP, ST_SLOW_ONLY, ST_BOTH, ST_FAST_ONLY
  } scpm_state_t;

  // Gated clock enable pulses
  typedef struct packed {
    logic sys;
    logic fast;
    logic slow;
    logic internal_slow_oscillator;
  } scpm_clk_en_t;

endpackage : scpm_pkg

// File: testbench/scpm_monitor.sv
// Port-level checks of bus timing and halt behaviour
`timescale 1ns/1ps
module scpm_monitor (
  input wire logic                   CLK,
  input wire logic                   NRST,
  input wire logic                   PSEL,
  input wire logic                   PENABLE,
  input wire logic                   PREADY,
  input wire logic                   PSLVERR,
  input wire logic                   HALT_REQ,
  input wire logic                   WAKE,
  input wire logic                   WDT_TIMEOUT,
  input wire logic                   CLR_WDT_CMD,
  input wire scpm_pkg::scpm_clk_en_t CLK_EN,
  input wire logic                   CPU_HALTED,
  input wire logic                   WDT_CLR,
  input wire logic                   PWR_DOWN_FLAG,
  input wire logic                   WDT_TO_FLAG
);
  // One clock domain for every check
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  // Bus answers after exactly one wait cycle, for one cycle
  a_pready_one_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("ready not on second access cycle");
  a_pready_single: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_slverr_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error response without ready");

  // Halt entry and the halted state
  a_halt_entry_flags: assert property (
    HALT_REQ && !CPU_HALTED |=> CPU_HALTED && WDT_CLR && PWR_DOWN_FLAG)
    else $error("halt entry did not set flags");
  a_halt_clears_to: assert property (
    HALT_REQ && !CPU_HALTED && !WDT_TIMEOUT |=> !WDT_TO_FLAG)
    else $error("time-out flag kept on halt entry");
  a_wdt_clr_once: assert property (
    WDT_CLR |-> $rose(CPU_HALTED) ##1 !WDT_CLR)
    else $error("watchdog clear not a single entry pulse");
  a_halt_holds: assert property (CPU_HALTED && !WAKE |=> CPU_HALTED)
    else $error("halt left without wake");
  a_sys_stopped: assert property (
    CPU_HALTED && $past(CPU_HALTED) |-> !CLK_EN.sys)
    else $error("system clock ticks while halted");
  a_pdf_sticky: assert property (
    PWR_DOWN_FLAG && !CLR_WDT_CMD |=> PWR_DOWN_FLAG)
    else $error("power-down flag lost without clear");

  // Main scenarios reached
  c_halt: cover property (HALT_REQ && !CPU_HALTED);
  c_wake: cover property (CPU_HALTED && WAKE);
  c_slverr: cover property (PSLVERR);
endmodule : scpm_monitor

// File: testbench/scpm_core_model.sv
// Processor core model turning halt and wake commands into pulses
`timescale 1ns/1ps
module scpm_core_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic halt_cmd,
  input  wire logic wake_cmd,
  output logic      halt_req,
  output logic      wake
);
  logic halt_seen_q;
  logic wake_seen_q;

  // One pulse per rising command, on the block's own clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      halt_req    <= 1'h0;
      wake        <= 1'h0;
      halt_seen_q <= 1'h0;
      wake_seen_q <= 1'h0;
    end else begin
      halt_req    <= halt_cmd && !halt_seen_q;
      wake        <= wake_cmd && !wake_seen_q;
      halt_seen_q <= halt_cmd;
      wake_seen_q <= wake_cmd;
    end
  end
endmodule : scpm_core_model

// File: testbench/system_clock_power_mode_ctrl_tb.sv
// Self-checking bench for the clock select and power mode controller
`timescale 1ns/1ps
module system_clock_power_mode_ctrl_tb;
  logic                   clk = 1'h0;
  logic                   nrst = 1'h0;
  logic                   psel = 1'h0;
  logic                   penable = 1'h0;
  logic                   pwrite = 1'h0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic                   halt_cmd = 1'h0;
  logic                   wake_cmd = 1'h0;
  logic                   wdt_en = 1'h0;
  logic                   wdt_timeout = 1'h0;
  logic                   clr_wdt_cmd = 1'h0;
  logic [31:0]            prdata;
  logic                   pready, pslverr, halt_req, wake;
  logic                   cpu_halted, wdt_clr, power_down_flag, to_flag, irq;
  scpm_pkg::scpm_clk_en_t clk_en;
  logic [31:0]            rdat;
  logic                   rerr;
  int                     fails = 0;
  int                     check_count = 0;
  int                     cycles = 0;

  scpm_top #(.FAST_STAB_TICKS(16'h0004), .SLOW_STAB_TICKS(16'h0002)) dut_u (
    .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .HALT_REQ(halt_req), .WAKE(wake), .WDT_EN(wdt_en),
    .WDT_TIMEOUT(wdt_timeout), .CLR_WDT_CMD(clr_wdt_cmd), .CLK_EN(clk_en),
    .CPU_HALTED(cpu_halted), .WDT_CLR(wdt_clr), .PWR_DOWN_FLAG(power_down_flag),
    .WDT_TO_FLAG(to_flag), .IRQ(irq));
  scpm_core_model core_u (.clk(clk), .nrst(nrst), .halt_cmd(halt_cmd),
    .wake_cmd(wake_cmd), .halt_req(halt_req), .wake(wake));

  // 25 MHz clock
  always #20 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One bus transfer, held until ready is sampled high; only the hang guard ends a wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(rdat, exp);
  endtask : rd

  // Poll status until the clock switch has finished
  task automatic wait_switch();
    int n;
    n = 0;
    rdat = 32'h4;
    while (rdat[scpm_pkg::PST_BUSY] !== 1'h0 && n < 2500) begin
      apb(1'h0, scpm_pkg::OFF_PWR_STS, 32'h0);
      n++;
    end
  endtask : wait_switch

  task automatic t_reset();
    rd(scpm_pkg::OFF_FOSC_CTL, 32'h1);
    rd(scpm_pkg::OFF_CLK_SEL, 32'h0);
    apb(1'h1, 8'h14, 32'hff);
    check({31'h0, rerr}, 32'h1);
    apb(1'h1, scpm_pkg::OFF_PWR_STS, 32'hff);
    rd(scpm_pkg::OFF_PWR_STS, 32'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_fosc();
    int n;
    n = 0;
    apb(1'h1, scpm_pkg::OFF_FOSC_CTL, 32'hfffffffe);
    rd(scpm_pkg::OFF_FOSC_CTL, 32'h0);
    apb(1'h1, scpm_pkg::OFF_FOSC_CTL, 32'hff);
    rd(scpm_pkg::OFF_FOSC_CTL, 32'h1);
    while (rdat[scpm_pkg::FOSC_STABLE] !== 1'h1 && n < 100) begin
      apb(1'h0, scpm_pkg::OFF_FOSC_CTL, 32'h0);
      n++;
    end
    check(rdat, 32'h3);
    apb(1'h1, scpm_pkg::OFF_CLK_SEL, 32'h1f);
    rd(scpm_pkg::OFF_CLK_SEL, 32'h3);
    $display("t_fosc done");
  endtask : t_fosc

  task automatic t_switch();
    int nf, ny;
    apb(1'h1, scpm_pkg::OFF_CLK_SEL, 32'he0);
    apb(1'h0, scpm_pkg::OFF_PWR_STS, 32'h0);
    check({31'h0, rdat[scpm_pkg::PST_BUSY]}, 32'h1);
    wait_switch();
    check({29'h0, rdat[7:5]}, 32'h7);
    check({31'h0, rdat[scpm_pkg::PST_SLOW_OK]}, 32'h1);
    check({31'h0, irq}, 32'h0);
    apb(1'h1, scpm_pkg::OFF_IRQ_MSK, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'h1, scpm_pkg::OFF_IRQ_STS, 32'h1);
    check({31'h0, irq}, 32'h0);
    apb(1'h1, scpm_pkg::OFF_CLK_SEL, 32'h20);
    wait_switch();
    check({29'h0, rdat[7:5]}, 32'h1);
    apb(1'h1, scpm_pkg::OFF_CLK_SEL, 32'hc0);
    wait_switch();
    check({29'h0, rdat[7:5]}, 32'h6);
    // Code 110 gives one system tick per 64 fast ticks
    nf = 0;
    ny = 0;
    repeat (800) begin
      @(posedge clk);
      nf += int'(clk_en.fast);
      ny += int'(clk_en.sys);
    end
    check({31'h0, (ny * 64 <= nf + 63) && (nf <= ny * 64 + 63) && ny > 0}, 32'h1);
    apb(1'h1, scpm_pkg::OFF_CLK_SEL, 32'h0);
    wait_switch();
    check({29'h0, rdat[7:5]}, 32'h0);
    $display("t_switch done");
  endtask : t_switch

  // Halt with the given keep bits, watch the gated clocks, then wake
  task automatic t_halt(input logic [1:0] keep);
    int nf, ns, ny, nl;
    nf = 0;
    ns = 0;
    ny = 0;
    nl = 0;
    apb(1'h1, scpm_pkg::OFF_CLK_SEL, {30'h0, keep});
    wdt_en <= ~keep[1];
    wdt_timeout <= 1'h1;
    @(posedge clk);
    wdt_timeout <= 1'h0;
    halt_cmd <= 1'h1;
    for (int i = 0; i < 10 && cpu_halted !== 1'h1; i++) @(posedge clk);
    check({30'h0, to_flag, power_down_flag}, 32'h1);
    repeat (1700) begin
      @(posedge clk);
      nf += int'(clk_en.fast);
      ns += int'(clk_en.slow);
      ny += int'(clk_en.sys);
      nl += int'(clk_en.internal_slow_oscillator);
    end
    check({31'h0, nf != 0}, {31'h0, keep[1]});
    check({31'h0, nl != 0}, {31'h0, keep[0] | ~keep[1]});
    check({31'h0, ns != 0}, {31'h0, keep[0]});
    check(ny, 32'h0);
    rd(scpm_pkg::OFF_CLK_SEL, {30'h0, keep});
    halt_cmd <= 1'h0;
    wake_cmd <= 1'h1;
    for (int i = 0; i < 10 && cpu_halted !== 1'h0; i++) @(posedge clk);
    check({31'h0, cpu_halted}, 32'h0);
    clr_wdt_cmd <= 1'h1;
    wake_cmd <= 1'h0;
    @(posedge clk);
    clr_wdt_cmd <= 1'h0;
    @(posedge clk);
    check({31'h0, power_down_flag}, 32'h0);
    $display("t_halt %0d done", keep);
  endtask : t_halt

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    t_reset();
    t_fosc();
    t_switch();
    // Order 00, 01, 11, 10: fast-only halt last, as it stops the slow oscillator
    for (int k = 0; k < 4; k++) t_halt(k[1:0] ^ {1'h0, k[1]});
    summarize();
  end
endmodule : system_clock_power_mode_ctrl_tb

bind scpm_top scpm_monitor mon_u (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .HALT_REQ(HALT_REQ),
  .WAKE(WAKE), .WDT_TIMEOUT(WDT_TIMEOUT), .CLR_WDT_CMD(CLR_WDT_CMD),
  .CLK_EN(CLK_EN), .CPU_HALTED(CPU_HALTED), .WDT_CLR(WDT_CLR),
  .PWR_DOWN_FLAG(PWR_DOWN_FLAG), .WDT_TO_FLAG(WDT_TO_FLAG));
